//--- shared/aoed_pkg.sv
/*
 * aoed_pkg: error codes, clear attributes, register map and reset values
 * for the axis operation error detector.
 * assumes a 32-bit register port with byte addresses, one word per register.
 */
package aoed_pkg;
    localparam int unsigned AOED_NERR = 16;   // error kinds per axis
    localparam int unsigned AOED_AW   = 8;    // register address width

    // error kind index within an axis status word
    localparam int unsigned E_NREADY = 0;
    localparam int unsigned E_SOFF   = 1;
    localparam int unsigned E_MPWR   = 2;
    localparam int unsigned E_LIMP   = 3;
    localparam int unsigned E_LIMN   = 4;
    localparam int unsigned E_LIMB   = 5;
    localparam int unsigned E_SWP    = 6;
    localparam int unsigned E_SWN    = 7;
    localparam int unsigned E_SPD1   = 8;
    localparam int unsigned E_AXOP   = 11;
    localparam int unsigned E_ABEND  = 12;
    localparam int unsigned E_GRP    = 13;
    localparam int unsigned E_INTP   = 14;
    localparam int unsigned E_GPUL   = 15;

    typedef logic [AOED_NERR-1:0][15:0] aoed_code_t;
    // reported code of each error kind, index 15 first (packed, msb left)
    localparam aoed_code_t AOED_CODE = {
        16'h3034, 16'h3033, 16'h3032, 16'h3031,
        16'h3030, 16'h3027, 16'h3026, 16'h3025,
        16'h3021, 16'h3020, 16'h3012, 16'h3011,
        16'h3010, 16'h3005, 16'h3001, 16'h3000};
    // clear attribute per kind: one means software may clear it
    localparam logic [AOED_NERR-1:0] AOED_CLEARABLE = 16'hffff;

    // register map (byte addresses)
    localparam logic [AOED_AW-1:0] A_MASK    = 8'h00;
    localparam logic [AOED_AW-1:0] A_LAST    = 8'h04;
    localparam logic [AOED_AW-1:0] A_STAT    = 8'h10;
    localparam logic [AOED_AW-1:0] A_UPPER   = 8'h40;
    localparam logic [AOED_AW-1:0] A_LOWER   = 8'h60;
    localparam logic [AOED_AW-1:0] A_BLK     = 8'h20;  // span of one array
    localparam int unsigned        A_SHIFT   = 2;      // word stride

    localparam logic [15:0] MASK_RST  = 16'h0000;
    localparam logic [31:0] UPPER_RST = 32'h7fffffff;
    localparam logic [31:0] LOWER_RST = 32'h80000000;
endpackage : aoed_pkg

//--- core/aoed_report.sv
/*
 * aoed_report: holds raised errors until each is handed to the host as
 * one code word with its axis number, one per cycle, an all-axes abend first, then lowest axis first.
 * assumes events are one-cycle pulses from the detector in the same clock.
 */
`timescale 1ns/10ps
module aoed_report
    import aoed_pkg::*;
#(
    parameter int unsigned NAXES = 4,
    parameter int unsigned XW    = 3
) (
    input  wire logic                              clk_in,
    input  wire logic                              nrst_in,
    input  wire logic [NAXES-1:0][AOED_NERR-1:0]   evt_in,
    input  wire logic                              all_in,
    output logic                                   rep_valid_out,
    output logic [15:0]                            rep_code_out,
    output logic [XW-1:0]                          rep_axis_out,
    output logic                                   rep_all_out
);
    typedef struct packed {
        logic [NAXES-1:0][AOED_NERR-1:0] pend;
        logic                            pall;
        logic                            vld;
        logic [15:0]                     code;
        logic [XW-1:0]                   axis;
        logic                            all;
    } aoed_rep_s;

    aoed_rep_s s_reg, s_next;
    logic      found;

    // pick one pending entry; new events always win over the take
    always_comb begin
        s_next     = s_reg;
        found      = 1'b0;
        s_next.vld = 1'b0;
        if (s_reg.pall) begin
            s_next.pall = 1'b0;
            s_next.vld  = 1'b1;
            s_next.code = AOED_CODE[E_ABEND];
            s_next.axis = '0;
            s_next.all  = 1'b1;            // all-axes indication
            found       = 1'b1;
        end
        for (int a = 0; a < NAXES; a++) begin
            for (int k = 0; k < AOED_NERR; k++) begin
                if (!found && s_reg.pend[a][k]) begin
                    found             = 1'b1;
                    s_next.pend[a][k] = 1'b0;
                    s_next.vld        = 1'b1;
                    s_next.code       = AOED_CODE[k];  // 16-bit code
                    s_next.axis       = XW'(a);
                    s_next.all        = 1'b0;
                end
            end
        end
        s_next.pend = s_next.pend | evt_in;
        s_next.pall = s_next.pall | all_in;
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rep_valid_out = s_reg.vld;
    assign rep_code_out  = s_reg.code;
    assign rep_axis_out  = s_reg.axis;
    assign rep_all_out   = s_reg.all;
endmodule : aoed_report

//--- core/aoed_detect.sv
/*
 * aoed_detect: per-axis operation error detection with status, mask and
 * software limit registers, one interrupt and a code report stream.
 * assumes all inputs synchronous to clk_in and a single-cycle register port.
 */
//
// Contract
// - start without servo lock flags not-ready
// - servo off while busy flags error
// - servo-on with main power off flags
// - plus limit input active flags error
// - minus limit input active flags error
// - both limits active give distinct code
// - position above upper soft limit flags
// - position below lower soft limit flags
// - speed computation overflow gives three codes
// - internal fault gives axis or abend code
// - group change while busy/stop or unconnected
// - interpolation fault stops, flags other axes
// - group change during pulser flags error
// - each error carries a clearable attribute
`timescale 1ns/10ps
module aoed_detect
    import aoed_pkg::*;
#(
    parameter int unsigned NAXES = 4,
    parameter int unsigned XW    = 3,
    parameter int unsigned PW    = 32
) (
    input  wire logic                           clk_in,
    input  wire logic                           nrst_in,
    input  wire logic [AOED_AW-1:0]             addr_in,
    input  wire logic [31:0]                    wdata_in,
    input  wire logic                           wr_in,
    input  wire logic                           rd_in,
    output logic [31:0]                         rdata_out,
    output logic                                irq_out,
    input  wire logic [NAXES-1:0]               start_req_in,
    input  wire logic [NAXES-1:0]               servo_lock_in,
    input  wire logic [NAXES-1:0]               busy_in,
    input  wire logic [NAXES-1:0]               servo_on_req_in,
    input  wire logic [NAXES-1:0]               main_pwr_in,
    input  wire logic [NAXES-1:0]               lim_pos_in,
    input  wire logic [NAXES-1:0]               lim_neg_in,
    input  wire logic [NAXES-1:0][PW-1:0]       pos_in,
    input  wire logic [NAXES-1:0][2:0]          spd_ovf_in,
    input  wire logic [NAXES-1:0]               axis_fault_in,
    input  wire logic [NAXES-1:0]               abend_in,
    input  wire logic                           abend_all_in,
    input  wire logic [NAXES-1:0]               stop_req_in,
    input  wire logic [NAXES-1:0][NAXES-1:0]    grp_in,
    input  wire logic [NAXES-1:0]               connected_in,
    input  wire logic [NAXES-1:0]               interp_in,
    input  wire logic [NAXES-1:0]               pulser_en_in,
    output logic [NAXES-1:0]                    interp_stop_out,
    output logic                                rep_valid_out,
    output logic [15:0]                         rep_code_out,
    output logic [XW-1:0]                       rep_axis_out,
    output logic                                rep_all_out
);
    typedef struct packed {
        logic [NAXES-1:0][AOED_NERR-1:0] stat;
        logic [AOED_NERR-1:0]            mask;
        logic [NAXES-1:0][PW-1:0]        upper;
        logic [NAXES-1:0][PW-1:0]        lower;
        logic [NAXES-1:0]                lock_d;
        logic [NAXES-1:0]                limp_d;
        logic [NAXES-1:0]                limn_d;
        logic [NAXES-1:0]                swp_d;
        logic [NAXES-1:0]                swn_d;
        logic [NAXES-1:0][NAXES-1:0]     grp_d;
        logic [NAXES-1:0]                istop;
        logic [31:0]                     rdata;
    } aoed_det_s;

    aoed_det_s                        s_reg, s_next;
    logic [NAXES-1:0][AOED_NERR-1:0]  evt;
    logic [NAXES-1:0]                 fault;
    logic [NAXES-1:0]                 swp, swn, grp_chg;
    logic [15:0]                      last_code;
    logic [XW-1:0]                    last_axis;
    logic                             last_all;

    // true when addr falls in the array starting at base, returns slot
    function automatic logic in_blk(input logic [AOED_AW-1:0] adr,
                                    input logic [AOED_AW-1:0] base);
        return (adr >= base) && (adr < base + A_BLK) &&
               (32'(adr - base) >> A_SHIFT) < NAXES &&
               (adr[A_SHIFT-1:0] == '0);
    endfunction : in_blk

    function automatic int unsigned slot(input logic [AOED_AW-1:0] adr,
                                         input logic [AOED_AW-1:0] base);
        return 32'(adr - base) >> A_SHIFT;
    endfunction : slot

    // per-axis condition decode; lock loss, limits, soft limits and group changes are edge-qualified to give single pulses
    always_comb begin
        evt   = '0;
        fault = '0;
        for (int a = 0; a < NAXES; a++) begin
            swp[a] = $signed(pos_in[a]) > $signed(s_reg.upper[a]);
            swn[a] = $signed(pos_in[a]) < $signed(s_reg.lower[a]);
            grp_chg[a] = grp_in[a] != s_reg.grp_d[a];
            evt[a][E_NREADY] = start_req_in[a] & ~servo_lock_in[a];
            // host is expected to keep servo-on while busy
            evt[a][E_SOFF] = busy_in[a] & s_reg.lock_d[a]
                             & ~servo_lock_in[a];
            evt[a][E_MPWR] = servo_on_req_in[a] & ~main_pwr_in[a];
            // single-side codes only while the other side is quiet
            evt[a][E_LIMP] = lim_pos_in[a] & ~s_reg.limp_d[a]
                             & ~lim_neg_in[a];
            evt[a][E_LIMN] = lim_neg_in[a] & ~s_reg.limn_d[a]
                             & ~lim_pos_in[a];
            evt[a][E_LIMB] = lim_pos_in[a] & lim_neg_in[a]
                             & ~(s_reg.limp_d[a] & s_reg.limn_d[a]);
            evt[a][E_SWP] = swp[a] & ~s_reg.swp_d[a];
            evt[a][E_SWN] = swn[a] & ~s_reg.swn_d[a];
            evt[a][E_SPD1 +: 3] = spd_ovf_in[a];
            evt[a][E_AXOP] = axis_fault_in[a];
            evt[a][E_ABEND] = abend_in[a];
            // changing a group while moving or stopping, or naming a
            // missing axis, is refused only by flagging it
            evt[a][E_GRP] = grp_chg[a] & ((busy_in[a] | stop_req_in[a])
                            | |(grp_in[a] & ~connected_in));
            // host keeps groups fixed while pulser runs
            evt[a][E_GPUL] = grp_chg[a] & pulser_en_in[a];
            fault[a] = interp_in[a] & |evt[a][E_GPUL-1:0];
        end
        // a fault on one interpolating axis flags the others
        for (int a = 0; a < NAXES; a++) begin
            evt[a][E_INTP] = interp_in[a] & ~fault[a] & |fault;
        end
    end

    // register file, status sticky bits and edge history
    always_comb begin
        s_next       = s_reg;
        s_next.rdata = '0;
        s_next.istop = interp_in & {NAXES{|fault}};
        s_next.lock_d = servo_lock_in;
        s_next.limp_d = lim_pos_in;
        s_next.limn_d = lim_neg_in;
        s_next.swp_d  = swp;
        s_next.swn_d  = swn;
        s_next.grp_d  = grp_in;
        if (wr_in) begin
            if (addr_in == A_MASK) begin
                s_next.mask = wdata_in[AOED_NERR-1:0];
            end
            for (int a = 0; a < NAXES; a++) begin
                // non-clearable kinds ignore the clear write
                if (in_blk(addr_in, A_STAT) && slot(addr_in, A_STAT) == a) begin
                    s_next.stat[a] = s_reg.stat[a]
                        & ~(wdata_in[AOED_NERR-1:0] & AOED_CLEARABLE);
                end
                if (in_blk(addr_in, A_UPPER) && slot(addr_in, A_UPPER) == a) begin
                    s_next.upper[a] = wdata_in[PW-1:0];
                end
                if (in_blk(addr_in, A_LOWER) && slot(addr_in, A_LOWER) == a) begin
                    s_next.lower[a] = wdata_in[PW-1:0];
                end
            end
        end
        // set wins over a clear written in the same cycle
        s_next.stat = s_next.stat | evt;
        for (int a = 0; a < NAXES; a++) begin
            if (abend_all_in) begin
                s_next.stat[a][E_ABEND] = 1'b1;
            end
        end
        if (rd_in) begin
            if (addr_in == A_MASK) begin
                s_next.rdata = 32'(s_reg.mask);
            end
            if (addr_in == A_LAST) begin
                s_next.rdata = {last_all, 7'h00, 8'(last_axis), last_code};
            end
            for (int a = 0; a < NAXES; a++) begin
                if (in_blk(addr_in, A_STAT) && slot(addr_in, A_STAT) == a) begin
                    s_next.rdata = 32'(s_reg.stat[a]);
                end
                if (in_blk(addr_in, A_UPPER) && slot(addr_in, A_UPPER) == a) begin
                    s_next.rdata = 32'(s_reg.upper[a]);
                end
                if (in_blk(addr_in, A_LOWER) && slot(addr_in, A_LOWER) == a) begin
                    s_next.rdata = 32'(s_reg.lower[a]);
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg       <= '0;
            s_reg.mask  <= MASK_RST;
            s_reg.upper <= {NAXES{PW'(UPPER_RST)}};
            s_reg.lower <= {NAXES{PW'(LOWER_RST)}};
        end else begin
            s_reg <= s_next;
        end
    end

    // code stream to the host; the last code is also kept for software
    aoed_report #(
        .NAXES (NAXES),
        .XW    (XW)
    ) u_report (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .evt_in        (evt),
        .all_in        (abend_all_in),
        .rep_valid_out (rep_valid_out),
        .rep_code_out  (rep_code_out),
        .rep_axis_out  (rep_axis_out),
        .rep_all_out   (rep_all_out)
    );

    logic [15:0]   lc_reg;
    logic [XW-1:0] la_reg;
    logic          ll_reg;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            lc_reg <= '0;
            la_reg <= '0;
            ll_reg <= 1'b0;
        end else if (rep_valid_out) begin
            lc_reg <= rep_code_out;
            la_reg <= rep_axis_out;
            ll_reg <= rep_all_out;
        end
    end
    assign last_code = lc_reg;
    assign last_axis = la_reg;
    assign last_all  = ll_reg;

    // level interrupt: any unmasked sticky bit on any axis
    always_comb begin
        irq_out = 1'b0;
        for (int a = 0; a < NAXES; a++) begin
            irq_out = irq_out | |(s_reg.stat[a] & s_reg.mask);
        end
    end
    assign rdata_out       = s_reg.rdata;
    assign interp_stop_out = s_reg.istop;

    // checks
    sequence s_start_unlocked;
        start_req_in[0] && !servo_lock_in[0];
    endsequence
    sequence s_lock_lost;
        busy_in[0] && servo_lock_in[0] ##1 busy_in[0] && !servo_lock_in[0];
    endsequence

    a_nready_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_start_unlocked |=> s_reg.stat[0][E_NREADY])
        else $error("not-ready not flagged");
    a_servo_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        s_lock_lost |=> s_reg.stat[0][E_SOFF])
        else $error("servo off in operation not flagged");
    a_mpwr_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        servo_on_req_in[0] && !main_pwr_in[0] |=> s_reg.stat[0][E_MPWR])
        else $error("main power error missing");
    a_lim_both: assert property (@(posedge clk_in) disable iff (!nrst_in)
        evt[0][E_LIMB] |-> !evt[0][E_LIMP] && !evt[0][E_LIMN])
        else $error("both-limit case gave single-side code");
    a_limp_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !lim_pos_in[0] && !lim_neg_in[0] ##1 lim_pos_in[0] && !lim_neg_in[0]
        |=> s_reg.stat[0][E_LIMP])
        else $error("plus limit not flagged");
    a_swp_flag: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !swp[0] ##1 swp[0] |=> s_reg.stat[0][E_SWP])
        else $error("upper soft limit not flagged");
    a_intp_stop: assert property (@(posedge clk_in) disable iff (!nrst_in)
        |fault && interp_in[0] |=> interp_stop_out[0])
        else $error("interpolation stop missing");
    a_grp_pulser: assert property (@(posedge clk_in) disable iff (!nrst_in)
        grp_chg[0] && pulser_en_in[0] |=> s_reg.stat[0][E_GPUL])
        else $error("group change in pulser not flagged");
    a_report_soon: assert property (@(posedge clk_in) disable iff (!nrst_in)
        |evt |-> ##[1:64] rep_valid_out)
        else $error("raised error never reported");
    a_set_wins: assert property (@(posedge clk_in) disable iff (!nrst_in)
        evt[0][E_AXOP] && wr_in && addr_in == A_STAT
        |=> s_reg.stat[0][E_AXOP])
        else $error("clear beat a new event");
endmodule : aoed_detect

//--- tb/aoed_amp_model.sv
/*
 * aoed_amp_model: the servo amplifiers on the network, one per axis.
 * assumes the host drives servo-on and main power per axis; trip_in
 * stands for an amplifier alarm that drops the servo lock.
 */
`timescale 1ns/10ps
module aoed_amp_model
    import aoed_pkg::*;
#(
    parameter int unsigned NAXES    = 4,
    parameter int unsigned LOCK_DLY = 3
) (
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic [NAXES-1:0] servo_on_req_in,
    input  wire logic [NAXES-1:0] main_pwr_in,
    input  wire logic [NAXES-1:0] trip_in,
    output logic      [NAXES-1:0] servo_lock_out
);
    int unsigned cnt [NAXES];

    // lock only after the loop settles (slow answer when LOCK_DLY is big);
    // loss of request, power or an alarm drops lock at the next edge
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            servo_lock_out <= '0;
            for (int a = 0; a < NAXES; a++) cnt[a] <= 0;
        end else begin
            for (int a = 0; a < NAXES; a++) begin
                if (!(servo_on_req_in[a] && main_pwr_in[a]) || trip_in[a]) begin
                    cnt[a]            <= 0;
                    servo_lock_out[a] <= 1'b0;
                end else if (cnt[a] < LOCK_DLY) begin
                    cnt[a] <= cnt[a] + 1;
                end else begin
                    servo_lock_out[a] <= 1'b1;
                end
            end
        end
    end
endmodule : aoed_amp_model

//--- tb/tb.sv
/*
 * tb: self-checking bench for aoed_detect, one task per scenario.
 * assumes the amplifier model aoed_amp_model and a 125 MHz clock.
 */
`timescale 1ns/10ps
module tb
    import aoed_pkg::*;
;
    localparam int unsigned NAXES = 4;
    logic clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0] addr_in = '0;
    logic [31:0] wdata_in = '0, rdata_out;
    logic irq_out, abend_all_in = 1'b0, rep_valid_out, rep_all_out;
    logic [NAXES-1:0] start_req_in = '0, busy_in = '0, lim_pos_in = '0;
    logic [NAXES-1:0] servo_on_req_in = '1, main_pwr_in = '1, trip = '0;
    logic [NAXES-1:0] lim_neg_in = '0, axis_fault_in = '0, abend_in = '0;
    logic [NAXES-1:0] stop_req_in = '0, connected_in = '1, interp_in = '0;
    logic [NAXES-1:0] pulser_en_in = '0, servo_lock_in, interp_stop_out;
    logic [NAXES-1:0] stops;
    logic [NAXES-1:0][31:0] pos_in = '0;
    logic [NAXES-1:0][2:0] spd_ovf_in = '0;
    logic [NAXES-1:0][NAXES-1:0] grp_in = '0;
    logic [15:0] rep_code_out;
    logic [2:0] rep_axis_out;
    logic [31:0] reps[$];
    int miscompares = 0;
    int n_tests = 0;

    always #4 clk_in = ~clk_in;

    aoed_detect #(.NAXES(4), .XW(3), .PW(32)) aoed_detect_i (
        .clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .irq_out, .start_req_in, .servo_lock_in, .busy_in, .servo_on_req_in,
        .main_pwr_in, .lim_pos_in, .lim_neg_in, .pos_in, .spd_ovf_in,
        .axis_fault_in, .abend_in, .abend_all_in, .stop_req_in, .grp_in,
        .connected_in, .interp_in, .pulser_en_in, .interp_stop_out,
        .rep_valid_out, .rep_code_out, .rep_axis_out, .rep_all_out);

    aoed_amp_model #(.NAXES(4), .LOCK_DLY(3)) aoed_amp_model_i (
        .clk_in, .nrst_in, .servo_on_req_in, .main_pwr_in, .trip_in(trip),
        .servo_lock_out(servo_lock_in));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // register port: strobes one cycle, read data only in the next cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a; wdata_in <= d; wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a; rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    // gathers reports in the last-report layout and any interp stop pulse;
    // called at an edge, it looks 1 ns later first, so a one-cycle pulse
    // launched at the calling edge is not missed
    task automatic collect(input int n);
        reps.delete();
        stops = '0;
        repeat (n) begin
            #1;
            stops = stops | interp_stop_out;
            if (rep_valid_out === 1'b1)
                reps.push_back({rep_all_out, 12'h0, rep_axis_out, rep_code_out});
            @(posedge clk_in);
        end
    endtask : collect

    task automatic expect_rep(input string name, input logic [15:0] code,
                              input logic [2:0] ax, input logic all);
        logic [31:0] want;
        logic [31:0] seen;
        want = {all, 12'h0, ax, code};
        seen = 32'h0;
        foreach (reps[i]) if (reps[i] === want) seen = want;
        chk(name, want, seen);
    endtask : expect_rep

    // one-cycle event: 0 start, 1 speed overflow k, 2 fault, 3 abend, 4 all
    task automatic fire(input int sel, input int ax, input int k);
        @(posedge clk_in);
        case (sel)
            0: start_req_in[ax] <= 1'b1;
            1: spd_ovf_in[ax][k] <= 1'b1;
            2: axis_fault_in[ax] <= 1'b1;
            3: abend_in[ax] <= 1'b1;
            default: abend_all_in <= 1'b1;
        endcase
        @(posedge clk_in);
        start_req_in <= '0; spd_ovf_in <= '0; axis_fault_in <= '0;
        abend_in <= '0; abend_all_in <= 1'b0;
        collect(8);
    endtask : fire

    task automatic t_reset();
        logic [31:0] d;
        rd(A_MASK, d); chk("mask", 32'h0, d);
        rd(A_UPPER + 8'h0c, d); chk("upper", 32'h7fffffff, d);
        rd(A_LOWER, d); chk("lower", 32'h80000000, d);
        rd(A_STAT, d); chk("stat", 32'h0, d);
        rd(8'hfc, d); chk("unmapped", 32'h0, d);
        $display("test reset done");
    endtask : t_reset

    task automatic t_limits();
        logic [31:0] d;
        wr(A_MASK, 32'h0008);
        @(posedge clk_in); lim_pos_in[1] <= 1'b1;
        collect(4); expect_rep("lim_pos", 16'h3010, 3'd1, 1'b0);
        chk("irq_set", 32'h1, {31'h0, irq_out});
        lim_pos_in[1] <= 1'b0; @(posedge clk_in); lim_neg_in[1] <= 1'b1;
        collect(4); expect_rep("lim_neg", 16'h3011, 3'd1, 1'b0);
        lim_neg_in[1] <= 1'b0; @(posedge clk_in);
        lim_pos_in[1] <= 1'b1; lim_neg_in[1] <= 1'b1;
        collect(4); expect_rep("lim_both", 16'h3012, 3'd1, 1'b0);
        chk("lim_both_count", 32'h1, reps.size());
        lim_pos_in[1] <= 1'b0; lim_neg_in[1] <= 1'b0;
        rd(A_LAST, d); chk("last", 32'h00013012, d);
        rd(A_STAT + 8'h04, d); chk("stat1", 32'h0038, d);
        wr(A_STAT + 8'h04, 32'h0038);
        rd(A_STAT + 8'h04, d); chk("stat1_clr", 32'h0, d);
        chk("irq_clr", 32'h0, {31'h0, irq_out});
        $display("test limits done");
    endtask : t_limits

    task automatic t_servo();
        @(posedge clk_in); trip[0] <= 1'b1;
        repeat (2) @(posedge clk_in);
        fire(0, 0, 0); expect_rep("not_ready", 16'h3000, 3'd0, 1'b0);
        trip[0] <= 1'b0; repeat (8) @(posedge clk_in);
        busy_in[0] <= 1'b1; @(posedge clk_in); trip[0] <= 1'b1;
        collect(6); expect_rep("servo_off", 16'h3001, 3'd0, 1'b0);
        busy_in[0] <= 1'b0; trip[0] <= 1'b0;
        // servo-on dropped only with busy low
        @(posedge clk_in); servo_on_req_in[2] <= 1'b0; main_pwr_in[2] <= 1'b0;
        @(posedge clk_in); servo_on_req_in[2] <= 1'b1;
        @(posedge clk_in); servo_on_req_in[2] <= 1'b0;
        collect(6); expect_rep("main_pwr", 16'h3005, 3'd2, 1'b0);
        main_pwr_in[2] <= 1'b1; @(posedge clk_in); servo_on_req_in[2] <= 1'b1;
        repeat (8) @(posedge clk_in);
        $display("test servo done");
    endtask : t_servo

    task automatic t_soft();
        wr(A_UPPER + 8'h0c, 32'd100);
        wr(A_LOWER + 8'h0c, 32'hffffff9c);
        @(posedge clk_in); pos_in[3] <= 32'd100;
        collect(4); chk("soft_equal", 32'h0, reps.size());
        pos_in[3] <= 32'd101;
        collect(4); expect_rep("soft_up", 16'h3020, 3'd3, 1'b0);
        pos_in[3] <= 32'hffffff9b;
        collect(4); expect_rep("soft_lo", 16'h3021, 3'd3, 1'b0);
        pos_in[3] <= 32'h0;
        $display("test soft limits done");
    endtask : t_soft

    task automatic t_calc();
        logic [31:0] d;
        for (int k = 0; k < 3; k++) begin
            fire(1, 2, k);
            expect_rep("speed", 16'h3025 + 16'(k), 3'd2, 1'b0);
        end
        fire(2, 1, 0); expect_rep("axis_op", 16'h3030, 3'd1, 1'b0);
        fire(3, 1, 0); expect_rep("abend", 16'h3031, 3'd1, 1'b0);
        fire(4, 0, 0); expect_rep("abend_all", 16'h3031, 3'd0, 1'b1);
        // clear written in the very cycle the event sets: the set must win
        @(posedge clk_in);
        axis_fault_in[0] <= 1'b1;
        addr_in <= A_STAT;
        wdata_in <= 32'h0800;
        wr_in <= 1'b1;
        @(posedge clk_in);
        axis_fault_in[0] <= 1'b0;
        wr_in <= 1'b0;
        rd(A_STAT, d);
        chk("set_wins", 32'h0800, d & 32'h0800);
        $display("test internal faults done");
    endtask : t_calc

    task automatic t_group();
        // group changes are made with pulser off except where flagged
        @(posedge clk_in); busy_in[2] <= 1'b1;
        @(posedge clk_in); grp_in[2] <= 4'b0110;
        collect(6); expect_rep("grp_busy", 16'h3032, 3'd2, 1'b0);
        stop_req_in[3] <= 1'b1;
        @(posedge clk_in); grp_in[3] <= 4'b1000;
        collect(6); expect_rep("grp_stop", 16'h3032, 3'd3, 1'b0);
        stop_req_in[3] <= 1'b0;
        busy_in[2] <= 1'b0; connected_in <= 4'b0111;
        @(posedge clk_in); grp_in[0] <= 4'b1001;
        collect(6); expect_rep("grp_unconn", 16'h3032, 3'd0, 1'b0);
        connected_in <= 4'b1111; pulser_en_in[1] <= 1'b1;
        @(posedge clk_in); grp_in[1] <= 4'b0011;
        collect(6); expect_rep("grp_pulser", 16'h3034, 3'd1, 1'b0);
        pulser_en_in[1] <= 1'b0; interp_in <= 4'b0011;
        fire(2, 0, 0);
        chk("interp_stop", 32'h3, {28'h0, stops});
        expect_rep("interp", 16'h3033, 3'd1, 1'b0);
        interp_in <= '0;
        $display("test groups done");
    endtask : t_group

    // watchdog: the tests need a few hundred cycles at most
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (8) @(posedge clk_in);
        t_reset();
        t_limits();
        t_servo();
        t_soft();
        t_calc();
        t_group();
        finish_test();
    end
endmodule : tb
